// [shared/dual_timer_pkg.sv]
// constants, register map and types for the dual 8-bit timer/counter
package dual_timer_pkg;

  // channel count and counter width
  localparam int num_channels = 2;
  localparam int cnt_width    = 8;

  // register byte offsets
  localparam logic [7:0] ctrl0_ofs = 8'h00;
  localparam logic [7:0] cmp0_ofs  = 8'h04;
  localparam logic [7:0] ctrl1_ofs = 8'h08;
  localparam logic [7:0] cmp1_ofs  = 8'h0c;
  localparam logic [7:0] count0_ofs = 8'h10;
  localparam logic [7:0] count1_ofs = 8'h14;
  localparam logic [7:0] sys_ofs   = 8'h18;
  localparam int         addr_bits = 8;

  // reset values
  localparam logic [7:0] ctrl_reset = 8'h00;
  localparam logic [7:0] cmp_reset  = 8'hff;
  localparam logic [1:0] sys_reset  = 2'h0;

  // system configuration bit positions
  localparam int sys_tap_bit    = 0;
  localparam int sys_slow_bit   = 1;
  localparam int sys_toggle_lsb = 2;

  // operating mode encodings
  localparam logic [2:0] mode_timer_event = 3'h0;
  localparam logic [2:0] mode_divider     = 3'h1;
  localparam logic [2:0] mode_wide_timer  = 3'h4;

  // source clock selections
  localparam logic [2:0] sel_slowest = 3'h0;
  localparam logic [2:0] sel_fc_div7 = 3'h1;
  localparam logic [2:0] sel_fc_div5 = 3'h2;
  localparam logic [2:0] sel_fc_div3 = 3'h3;
  localparam logic [2:0] sel_pin     = 3'h7;

  // prescaler tap exponents
  localparam int div_exp_slowest = 11;
  localparam int div_exp_7       = 7;
  localparam int div_exp_5       = 5;
  localparam int div_exp_3       = 3;
  localparam logic [2:0] fs_div_last = 3'h7;

  // channel control byte, bit 7 down to bit 0
  typedef struct packed {
    logic       preset;
    logic [2:0] clk_sel;
    logic       start;
    logic [2:0] mode;
  } ctrl_type;

  // captured ahb address phase
  typedef struct packed {
    logic                 write;
    logic [addr_bits-1:0] addr;
  } ahb_phase_type;

endpackage

// [hw/dual_timer.sv]
// dual cascadable 8-bit timer / event counter / divider with ahb-lite registers
//
// The register offsets and register access over AHB-Lite are this design's own decisions.
module dual_timer
  import dual_timer_pkg::*;
#(
  parameter int PRESCALE_WIDTH = 11
) (
  input  wire logic                   sys_clk,
  input  wire logic                   resetn,
  input  wire logic                   hsel,
  input  wire logic [31:0]            haddr,
  input  wire logic [1:0]             htrans,
  input  wire logic                   hwrite,
  input  wire logic [2:0]             hsize,
  input  wire logic [31:0]            hwdata,
  input  wire logic                   hready,
  output logic                        hreadyout,
  output logic                        hresp,
  output logic [31:0]                 hrdata,
  input  wire logic                   fs_clk_pin,
  input  wire logic [num_channels-1:0] event_input_pin,
  output logic [num_channels-1:0]     divider_output_pin,
  output logic [num_channels-1:0]     match_interrupt
);

  // elaboration check on the prescaler width
  if (PRESCALE_WIDTH < div_exp_slowest) begin : g_bad_width
    $error("PRESCALE_WIDTH too small for the slowest tap");
  end

  // the read mux, the cascade and the status word assume exactly two channels
  if (num_channels != 2) begin : g_bad_chan
    $error("num_channels must be two for the cascade and read map");
  end

  // ahb bus state
  ahb_phase_type          phase_ff;
  logic                   wr_pend_ff;
  logic [31:0]            hrdata_ff;
  // register state
  ctrl_type               ctrl_ff   [num_channels];
  logic [cnt_width-1:0]   cmp_ff    [num_channels];
  logic [cnt_width-1:0]   cnt_ff    [num_channels];
  logic [cnt_width-1:0]   nxt_cnt   [num_channels];
  logic [num_channels-1:0] toggle_ff;
  logic [num_channels-1:0] nxt_toggle;
  logic [num_channels-1:0] irq_ff;
  logic [1:0]             sys_ff;
  // prescaler and synchronisers
  logic [PRESCALE_WIDTH-1:0] div_ff;
  logic                   fs_sync1_ff;
  logic                   fs_sync2_ff;
  logic                   fs_prev_ff;
  logic [2:0]             fs_div_ff;
  logic [num_channels-1:0] ev_sync1_ff;
  logic [num_channels-1:0] ev_sync2_ff;
  logic [num_channels-1:0] ev_prev_ff;

  // bus decode
  wire logic rd_req     = hsel && htrans[1] && !hwrite;
  wire logic addr_take  = hsel && htrans[1] && hready;
  // a pending write lands in its data phase even when that phase is stretched
  wire logic wr_commit  = wr_pend_ff;
  wire logic [addr_bits-1:0] rd_addr = haddr[addr_bits-1:0];
  wire logic wr_ctrl0   = wr_commit && (phase_ff.addr == ctrl0_ofs);
  wire logic wr_ctrl1   = wr_commit && (phase_ff.addr == ctrl1_ofs);
  wire logic wr_cmp0    = wr_commit && (phase_ff.addr == cmp0_ofs);
  wire logic wr_cmp1    = wr_commit && (phase_ff.addr == cmp1_ofs);
  wire logic wr_sys     = wr_commit && (phase_ff.addr == sys_ofs);
  wire logic [num_channels-1:0] wr_ctrl = {wr_ctrl1, wr_ctrl0};
  wire logic [num_channels-1:0] wr_cmp  = {wr_cmp1, wr_cmp0};
  wire ctrl_type wr_ctrl_val = ctrl_type'(hwdata[7:0]);

  // a read right behind a write waits one cycle so it sees the new value
  // the write lands in that stall cycle, so the wait never lasts longer
  assign hreadyout = !(wr_pend_ff && rd_req);
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_ff;

  // read data mux, unmapped addresses read zero
  logic [31:0] rd_mux;
  always_comb begin
    case (rd_addr)
      ctrl0_ofs:  rd_mux = {24'h0, ctrl_ff[0]};
      cmp0_ofs:   rd_mux = {24'h0, cmp_ff[0]};
      ctrl1_ofs:  rd_mux = {24'h0, ctrl_ff[1]};
      cmp1_ofs:   rd_mux = {24'h0, cmp_ff[1]};
      count0_ofs: rd_mux = {24'h0, cnt_ff[0]};
      count1_ofs: rd_mux = {24'h0, cnt_ff[1]};
      sys_ofs:    rd_mux = {28'h0, toggle_ff, sys_ff};
      default:    rd_mux = 32'h0;
    endcase
  end

  // address phase capture and read data
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      phase_ff   <= '0;
      wr_pend_ff <= 1'b0;
      hrdata_ff  <= 32'h0;
    end else if (hreadyout) begin
      wr_pend_ff     <= addr_take && hwrite;
      phase_ff.write <= hwrite;
      phase_ff.addr  <= haddr[addr_bits-1:0];
      if (addr_take && !hwrite) begin
        hrdata_ff <= rd_mux;
      end
    end else begin
      // the stalled cycle has committed the write; release the waiting read
      wr_pend_ff <= 1'b0;
    end
  end

  // free running fc prescaler
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      div_ff <= '0;
    end else begin
      div_ff <= div_ff + PRESCALE_WIDTH'(1);
    end
  end

  // low frequency clock pin: sync, rising edge, divide by eight
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      fs_sync1_ff <= 1'b0;
      fs_sync2_ff <= 1'b0;
      fs_prev_ff  <= 1'b0;
      fs_div_ff   <= 3'h0;
    end else begin
      fs_sync1_ff <= fs_clk_pin;
      fs_sync2_ff <= fs_sync1_ff;
      fs_prev_ff  <= fs_sync2_ff;
      if (fs_sync2_ff && !fs_prev_ff) begin
        fs_div_ff <= fs_div_ff + 3'h1;
      end
    end
  end

  // event pins: two-flop sync then falling edge
  // only the second flop feeds the edge detector, away from metastable samples
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      ev_sync1_ff <= '0;
      ev_sync2_ff <= '0;
      ev_prev_ff  <= '0;
    end else begin
      ev_sync1_ff <= event_input_pin;
      ev_sync2_ff <= ev_sync1_ff;
      ev_prev_ff  <= ev_sync2_ff;
    end
  end

  // prescaled tick enables
  wire logic fs_rise  = fs_sync2_ff && !fs_prev_ff;
  wire logic fs8_tick = fs_rise && (fs_div_ff == fs_div_last);
  wire logic fc11_tick = &div_ff[div_exp_slowest-1:0];
  wire logic fc7_tick  = &div_ff[div_exp_7-1:0];
  wire logic fc5_tick  = &div_ff[div_exp_5-1:0];
  wire logic fc3_tick  = &div_ff[div_exp_3-1:0];
  wire logic slowest_tick = sys_ff[sys_tap_bit] ? fs8_tick : fc11_tick;
  wire logic slow_mode    = sys_ff[sys_slow_bit];
  wire logic [num_channels-1:0] ev_fall = ev_prev_ff & ~ev_sync2_ff;

  // source tick for one channel given its selection and mode
  function automatic logic pick_tick(input logic [2:0] sel,
                                     input logic       divider,
                                     input logic       pin_fall);
    logic t;
    t = 1'b0;
    if (slow_mode) begin
      // only fs/8 internally, or the pin for event counting
      case (sel)
        // slow mode has no fc taps; the slowest select is always fs/8
        sel_slowest: t = fs8_tick;
        sel_pin:     t = !divider && pin_fall;
        default:     t = 1'b0;
      endcase
    end else begin
      case (sel)
        sel_slowest: t = slowest_tick;
        sel_fc_div7: t = fc7_tick;
        sel_fc_div5: t = fc5_tick;
        sel_fc_div3: t = fc3_tick;
        sel_pin:     t = !divider && pin_fall;
        default:     t = 1'b0;
      endcase
    end
    return t;
  endfunction

  // channel mode decode and source ticks
  wire logic wide = (ctrl_ff[1].mode == mode_wide_timer);
  logic [num_channels-1:0] own_tick;
  logic [num_channels-1:0] run;
  logic [num_channels-1:0] is_div;
  genvar gi;
  for (gi = 0; gi < num_channels; gi++) begin : g_src
    assign is_div[gi]   = (ctrl_ff[gi].mode == mode_divider) && !wide;
    assign run[gi]      = wide ? ctrl_ff[1].start : ctrl_ff[gi].start;
  end

  // source ticks; a process here so the tick nets read inside the function wake it
  always_comb begin
    for (int i = 0; i < num_channels; i++) begin
      own_tick[i] = pick_tick(ctrl_ff[i].clk_sel, is_div[i], ev_fall[i]);
    end
  end

  // 16-bit cascade view, clocked by the lower channel's source
  wire logic [2*cnt_width-1:0] wide_cnt = {cnt_ff[1], cnt_ff[0]};
  wire logic [2*cnt_width-1:0] wide_cmp = {cmp_ff[1], cmp_ff[0]};
  wire logic [2*cnt_width-1:0] wide_inc = wide_cnt + (2*cnt_width)'(1);
  wire logic wide_hit = (wide_inc == wide_cmp);
  wire logic [1:0] mode_ok;
  assign mode_ok[0] = (ctrl_ff[0].mode == mode_timer_event) || is_div[0];
  assign mode_ok[1] = (ctrl_ff[1].mode == mode_timer_event) || is_div[1];

  // next count and match; match clears the count at the tick that reaches compare
  // a compare of zero is outside the legal range and waits through a full wrap
  logic [num_channels-1:0] match;
  always_comb begin
    logic [cnt_width-1:0] inc;
    inc   = '0;
    match = '0;
    for (int i = 0; i < num_channels; i++) begin
      nxt_cnt[i] = cnt_ff[i];
    end
    if (wide) begin
      if (!run[1]) begin
        nxt_cnt[0] = '0;
        nxt_cnt[1] = '0;
      end else if (own_tick[0]) begin
        if (wide_hit) begin
          nxt_cnt[0] = '0;
          nxt_cnt[1] = '0;
          match[1]   = 1'b1;
        end else begin
          nxt_cnt[0] = wide_inc[cnt_width-1:0];
          nxt_cnt[1] = wide_inc[2*cnt_width-1:cnt_width];
        end
      end
    end else begin
      for (int i = 0; i < num_channels; i++) begin
        inc = cnt_ff[i] + cnt_width'(1);
        if (!run[i]) begin
          nxt_cnt[i] = '0;
        end else if (own_tick[i] && mode_ok[i]) begin
          // compare against the live register value
          if (inc == cmp_ff[i]) begin
            nxt_cnt[i] = '0;
            match[i]   = 1'b1;
          end else begin
            nxt_cnt[i] = inc;
          end
        end
      end
    end
  end

  // toggle flip-flop: flips on divider match, preset only while stopped
  // a match outranks a preset write in the same cycle
  always_comb begin
    for (int i = 0; i < num_channels; i++) begin
      nxt_toggle[i] = toggle_ff[i];
      if (match[i] && is_div[i]) begin
        nxt_toggle[i] = !toggle_ff[i];
      end else if (wr_ctrl[i] && !ctrl_ff[i].start) begin
        nxt_toggle[i] = wr_ctrl_val.preset;
      end
    end
  end

  // counters, toggles and interrupt pulses
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      toggle_ff <= '0;
      irq_ff    <= '0;
      for (int i = 0; i < num_channels; i++) begin
        cnt_ff[i] <= '0;
      end
    end else begin
      toggle_ff <= nxt_toggle;
      irq_ff    <= match;
      for (int i = 0; i < num_channels; i++) begin
        cnt_ff[i] <= nxt_cnt[i];
      end
    end
  end

  // software registers
  // compare writes land at once; there is no shadow copy to load later
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      sys_ff <= sys_reset;
      for (int i = 0; i < num_channels; i++) begin
        ctrl_ff[i] <= ctrl_type'(ctrl_reset);
        cmp_ff[i]  <= cmp_reset;
      end
    end else begin
      if (wr_sys) begin
        sys_ff <= hwdata[1:0];
      end
      for (int i = 0; i < num_channels; i++) begin
        if (wr_ctrl[i]) begin
          ctrl_ff[i] <= wr_ctrl_val;
        end
        if (wr_cmp[i]) begin
          cmp_ff[i] <= hwdata[cnt_width-1:0];
        end
      end
    end
  end

  // pin outputs
  // the divider pin is high after reset and low while the flip-flop is set
  assign divider_output_pin = ~toggle_ff;
  assign match_interrupt    = irq_ff;

endmodule

// [testbench/dual_timer_chk.sv]
// port-level checks for the dual timer
module dual_timer_chk
  import dual_timer_pkg::*;
#(
  parameter int PRESCALE_WIDTH = 11
) (
  input wire logic                    sys_clk,
  input wire logic                    resetn,
  input wire logic                    hsel,
  input wire logic [31:0]             haddr,
  input wire logic [1:0]              htrans,
  input wire logic                    hwrite,
  input wire logic [2:0]              hsize,
  input wire logic [31:0]             hwdata,
  input wire logic                    hready,
  input wire logic                    hreadyout,
  input wire logic                    hresp,
  input wire logic [31:0]             hrdata,
  input wire logic                    fs_clk_pin,
  input wire logic [num_channels-1:0] event_input_pin,
  input wire logic [num_channels-1:0] divider_output_pin,
  input wire logic [num_channels-1:0] match_interrupt
);
  logic wa_ff;
  // marks a write data phase
  always_ff @(posedge sys_clk) begin
    if (!resetn) wa_ff <= 1'b0;
    else if (hready) wa_ff <= hsel & htrans[1] & hwrite;
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("non okay response");
  a_irq_gap0: assert property (match_interrupt[0] |=> !match_interrupt[0] [*3])
    else $error("channel 0 match pulses too close");
  a_irq_gap1: assert property (match_interrupt[1] |=> !match_interrupt[1] [*3])
    else $error("channel 1 match pulses too close");
  a_reset_pin: assert property (disable iff (1'b0) !resetn |=> divider_output_pin == 2'b11)
    else $error("divider pins not high after reset");
  a_pin_cause: assert property (divider_output_pin != $past(divider_output_pin)
    |-> match_interrupt != 2'b00 || $past(wa_ff))
    else $error("divider pin moved without match or write");
  a_ready_low: assert property (!hreadyout |-> wa_ff)
    else $error("wait state outside write data phase");
  a_ready_bound: assert property (!hreadyout |=> hreadyout)
    else $error("wait state longer than one cycle");
  a_rd_upper: assert property (hrdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  c_irq0: cover property (match_interrupt[0]);
  c_irq1: cover property (match_interrupt[1]);
  c_wait: cover property (!hreadyout);
endmodule

bind dual_timer dual_timer_chk #(.PRESCALE_WIDTH(PRESCALE_WIDTH)) chk_i (.*);

// [testbench/event_source.sv]
// far side: event pulse source and slow clock pin
module event_source (
  input  wire logic       sys_clk,
  input  wire logic [1:0] divider_output_pin,
  output logic      [1:0] event_input_pin,
  output logic            fs_clk_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // divider load behind the shared port; its output latch is set to one
  logic [1:0] port_latch;
  wire logic [1:0] load_level = divider_output_pin & port_latch;
  initial begin
    port_latch = 2'b11;
    event_input_pin = 2'b11;
    fs_clk_pin = 1'b0;
  end
  // free running slow clock, period 16 cycles
  always begin
    repeat (8) @(posedge sys_clk);
    fs_clk_pin <= ~fs_clk_pin;
  end
  // n falling edges, each level held four cycles
  task automatic pulse(input int ch, input int n);
    repeat (n) begin
      repeat (4) @(posedge sys_clk);
      event_input_pin[ch] <= 1'b0;
      repeat (4) @(posedge sys_clk);
      event_input_pin[ch] <= 1'b1;
    end
  endtask
endmodule

// [testbench/dual_timer_test.sv]
// self-checking bench for the dual timer
`define chk(nm, e, s) begin n_checks++; if ((s) !== (e)) begin err_total++; \
  $display("MISMATCH %s exp %0h got %0h", nm, e, s); end end
module dual_timer_test
  import dual_timer_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk = 1'b0;
  logic        resetn = 1'b0;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, q;
  logic        hready, hreadyout, hresp, fs_clk_pin, v;
  logic [1:0]  event_input_pin, divider_output_pin, match_interrupt;
  int          err_total = 0;
  int          n_checks = 0;
  int          cyc = 0;
  int          irqs = 0;
  int          i0;
  assign hready = hreadyout;
  always #5 sys_clk = ~sys_clk;
  dual_timer #(.PRESCALE_WIDTH(11)) dut (
    .sys_clk(sys_clk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .fs_clk_pin(fs_clk_pin),
    .event_input_pin(event_input_pin), .divider_output_pin(divider_output_pin),
    .match_interrupt(match_interrupt));
  event_source src (.sys_clk(sys_clk), .event_input_pin(event_input_pin),
    .divider_output_pin(divider_output_pin), .fs_clk_pin(fs_clk_pin));
  // cycle ceiling and channel 0 match count
  always @(posedge sys_clk) begin
    cyc++;
    irqs += (match_interrupt[0] === 1'b1);
    if (cyc == 20000) begin
      err_total++;
      summarize();
    end
  end
  // one single ahb transfer, read data left in q
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic rd(input string nm, input logic [7:0] a, input int e);
    xfer(1'b0, a, 32'h0);
    `chk(nm, e, q)
  endtask
  function automatic logic sel(input int ch, input bit pin);
    return pin ? divider_output_pin[ch] : match_interrupt[ch];
  endfunction
  // cycles between pin changes, or between match pulses
  task automatic span(input int ch, input bit pin, input int e);
    int n;
    n = 0;
    v = pin ? divider_output_pin[ch] : 1'b0;
    do @(posedge sys_clk); while (sel(ch, pin) === v);
    if (pin) v = ~v;
    do begin
      @(posedge sys_clk);
      n++;
    end while (sel(ch, pin) === v);
    `chk("span", e, n)
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge sys_clk);
    resetn <= 1'b1;
    // reset values, unmapped hole, read-only count
    rd("ctrl0", ctrl0_ofs, ctrl_reset);
    rd("cmp1", cmp1_ofs, cmp_reset);
    rd("sys", sys_ofs, 0);
    `chk("pins", 2'b11, divider_output_pin)
    xfer(1'b1, 8'h1c, 32'h5a);
    rd("hole", 8'h1c, 0);
    xfer(1'b1, count0_ofs, 32'h7);
    rd("count0", count0_ofs, 0);
    // timer mode on fc/8, then a new compare value
    xfer(1'b1, cmp0_ofs, 32'h3);
    xfer(1'b1, ctrl0_ofs, 32'h38);
    span(0, 0, 24);
    `chk("pin0", 1'b1, divider_output_pin[0])
    xfer(1'b1, ctrl0_ofs, 32'h30);
    xfer(1'b1, cmp0_ofs, 32'h1);
    xfer(1'b1, ctrl0_ofs, 32'h38);
    span(0, 0, 8);
    // slow mode: fc/8 refused, fs/8 accepted
    xfer(1'b1, ctrl0_ofs, 32'h30);
    xfer(1'b1, sys_ofs, 32'h2);
    xfer(1'b1, ctrl0_ofs, 32'h38);
    repeat (64) @(posedge sys_clk);
    rd("slow", count0_ofs, 0);
    xfer(1'b1, ctrl0_ofs, 32'h30);
    xfer(1'b1, ctrl0_ofs, 32'h08);
    span(0, 0, 128);
    // normal mode: tap select gives fs/8, then fc/2048
    xfer(1'b1, ctrl0_ofs, 32'h00);
    xfer(1'b1, sys_ofs, 32'h1);
    xfer(1'b1, ctrl0_ofs, 32'h08);
    span(0, 0, 128);
    xfer(1'b1, ctrl0_ofs, 32'h00);
    xfer(1'b1, sys_ofs, 32'h0);
    xfer(1'b1, ctrl0_ofs, 32'h08);
    span(0, 0, 2048);
    xfer(1'b1, ctrl0_ofs, 32'h00);
    // event counting on the pin, compare 2, five falls
    xfer(1'b1, cmp0_ofs, 32'h2);
    xfer(1'b1, ctrl0_ofs, 32'h78);
    i0 = irqs;
    src.pulse(0, 5);
    repeat (8) @(posedge sys_clk);
    rd("events", count0_ofs, 1);
    `chk("matches", 2, irqs - i0)
    // divider output, compare 4 on fc/8
    xfer(1'b1, cmp1_ofs, 32'h4);
    xfer(1'b1, ctrl1_ofs, 32'h39);
    span(1, 1, 32);
    span(1, 1, 32);
    span(1, 0, 32);
    xfer(1'b1, ctrl1_ofs, 32'h31);
    v = divider_output_pin[1];
    repeat (64) @(posedge sys_clk);
    `chk("hold", v, divider_output_pin[1])
    rd("count1", count1_ofs, 0);
    xfer(1'b1, ctrl1_ofs, 32'hb1);
    @(posedge sys_clk);
    `chk("preset1", 1'b0, divider_output_pin[1])
    `chk("load1", 1'b0, src.load_level[1])
    rd("tff", sys_ofs, 8);
    xfer(1'b1, ctrl1_ofs, 32'h31);
    @(posedge sys_clk);
    `chk("preset0", 1'b1, divider_output_pin[1])
    // cascaded 16-bit count, clock from channel 0 select
    xfer(1'b1, ctrl0_ofs, 32'h30);
    xfer(1'b1, cmp0_ofs, 32'h3);
    xfer(1'b1, cmp1_ofs, 32'h0);
    xfer(1'b1, ctrl1_ofs, 32'h0c);
    span(1, 0, 24);
    summarize();
  end
endmodule
